// *** logic/wdr_pkg.sv ***
// What this block does
// - Default interval is 2^17 oscillator clocks.
// - Reset timeout follows interrupt by 512 cycles.
// - Every reset restores the shortest interval.
// - Select field multiplies interval by 1/8/64/512.
// - Base interval scales with the clock mode.
// - Watchdog reset only when reset enable set.
// - Restart bit begins a full new interval.
// - Masked reset gives periodic interrupt timeouts.
// - Timeout sets flag; enable gates the request.
// - Watchdog reset sets the reset cause flag.
// - Timeouts count system clock cycles.
// - Startup counter waits 65,536 crystal clocks.
// - Multiplier startup is timed by the watchdog.
// - Counting continues in idle; interrupt wakes.
// - Software reset holds 90 clocks, pin high.
// - Pin high three clocks enters reset.
// - Pin release waits 90 clocks or 4ms.
// - Leaving stop adds 65,536 clocks.
// - Internal resets drive the pin, ignore its level.
// - Enabled detector resets when crystal edges stop for one 20kHz period.
// - Detector enable and failure flag clear rules.
// - No failure reset during deliberate stop mode.
package wdr_pkg;
	localparam int          REG_AW            = 8;
	localparam int          REG_DW            = 8;
	localparam logic [7:0]  REG_POWER_CTRL    = 8'h87;
	localparam logic [7:0]  REG_CLOCK_CTRL    = 8'ha0;
	localparam logic [7:0]  REG_POWER_MODE    = 8'ha1;
	localparam logic [7:0]  REG_FLASH_CTRL    = 8'ha2;
	localparam logic [7:0]  REG_TIMED_ACCESS  = 8'hc7;
	localparam logic [7:0]  REG_WD_CTRL       = 8'hd8;
	localparam logic [7:0]  REG_EXT_IRQ_EN    = 8'he8;
	localparam int          WDC_RESTART       = 0;
	localparam int          WDC_RST_EN        = 1;
	localparam int          WDC_RST_FLAG      = 2;
	localparam int          WDC_IRQ_FLAG      = 3;
	localparam int          EIE_WD_IRQ_EN     = 4;
	localparam int          POWER_CONTROL_REG_OFD_EN       = 4;
	localparam int          POWER_CONTROL_REG_OFD_FLAG     = 5;
	localparam int          CK_SEL_LO         = 6;
	localparam int          CK_SEL_HI         = 7;
	localparam int          PM_RATIO          = 3;
	localparam int          PM_MULT_EN        = 4;
	localparam int          PM_CD_LO          = 6;
	localparam int          PM_CD_HI          = 7;
	localparam logic [1:0]  CD_MULT           = 2'h0;
	localparam logic [1:0]  CD_RSV            = 2'h1;
	localparam logic [1:0]  CD_DIV1           = 2'h2;
	localparam logic [1:0]  CD_SLOW           = 2'h3;
	localparam logic [7:0]  TA_KEY1           = 8'haa;
	localparam logic [7:0]  TA_KEY2           = 8'h55;
	localparam logic [1:0]  TA_WINDOW         = 2'h3;
	localparam logic [7:0]  FLASH_CMD_SYSRST  = 8'h0f;
	localparam int          OSC_LOG2          = 2;
	localparam int          SLOW_LOG2         = 12;
	localparam int          SEL_SHIFT         = 3;
	localparam int          SEL_SHIFT_MAX     = 9;
	localparam int          WD_BASE_LOG2      = 17;
	localparam int          WD_RST_CYC        = 512;
	localparam logic [8:0]  WD_RST_LAST       = 9'(WD_RST_CYC - 1);
	localparam logic [1:0]  PIN_HOLD_OSC      = 2'h3;
	localparam int          RELEASE_OSC       = 90;
	localparam int          STARTUP_OSC       = 65536;
	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          FLASH_BUSY_MS     = 4;
	localparam int          FLASH_BUSY_NS     = FLASH_BUSY_MS * 1000000;
	localparam int          OSC_FAIL_HZ       = 20000;
	localparam int          OSC_FAIL_NS       = 1000000000 / OSC_FAIL_HZ;

	typedef enum logic [1:0] {
		RS_RUN   = 2'b00,
		RS_HOLD  = 2'b01,
		RS_COUNT = 2'b10
	} wdr_rst_state_t;
endpackage

// *** logic/wdr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdr_sync (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// The filtered level moves only when the last two stages agree.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level <= s3_r;
			end
		end
	end
endmodule
`default_nettype wire

// *** logic/wdr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdr_top #(
	parameter int WD_BASE_LOG2   = wdr_pkg::WD_BASE_LOG2,
	parameter int STARTUP_OSC    = wdr_pkg::STARTUP_OSC,
	parameter int FLASH_BUSY_CYC = wdr_pkg::FLASH_BUSY_NS / wdr_pkg::CLK_PERIOD_NS,
	parameter int OSC_FAIL_CYC   = wdr_pkg::OSC_FAIL_NS / wdr_pkg::CLK_PERIOD_NS
) (
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic [wdr_pkg::REG_AW-1:0] reg_addr,
	input  wire logic [wdr_pkg::REG_DW-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [wdr_pkg::REG_DW-1:0] reg_rdata,
	input  wire logic                       pf_reset,
	input  wire logic                       flash_busy,
	input  wire logic                       stop_mode,
	input  wire logic                       xtal_sense,
	input  wire logic                       rst_pin_in,
	output logic                            rst_pin_out,
	output logic                            rst_pin_oe,
	output logic                            sys_reset,
	output logic                            sys_tick,
	output logic                            wd_irq_req,
	output logic                            xtal_ready,
	output logic                            mult_ready
);
	import wdr_pkg::*;

	localparam int CNT_W = WD_BASE_LOG2 + SEL_SHIFT_MAX;
	localparam int RW_F  = $clog2(FLASH_BUSY_CYC + 1);
	localparam int RW    = (RW_F > 8) ? RW_F : 8;
	localparam int SW    = $clog2(STARTUP_OSC + 1);
	localparam int GW    = $clog2(OSC_FAIL_CYC + 1);

	wdr_rst_state_t   state_r;
	logic [SLOW_LOG2-1:0] dcnt_r;
	logic             osc_en;
	logic             sys_en;
	logic [1:0]       sel_r;
	logic [1:0]       cd_r;
	logic             ctm_r;
	logic             ratio_r;
	logic             mult_ready_r;
	logic [1:0]       ta_arm_r;
	logic [1:0]       ta_open_r;
	logic             ta_open;
	logic [CNT_W-1:0] wd_cnt_r;
	logic             int_hit;
	logic             restart_now;
	logic             pend_r;
	logic [8:0]       pcnt_r;
	logic             wd_fire;
	logic             ewt_r;
	logic             watchdog_irq_flag_r;
	logic             watchdog_reset_flag_r;
	logic             watchdog_irq_enable_r;
	logic             osc_fail_detect_enable_r;
	logic             osc_fail_flag_r;
	logic             xtal_lvl;
	logic             xtal_prev_r;
	logic [GW-1:0]    gap_r;
	logic             ofail;
	logic             pin_lvl;
	logic [1:0]       phc_r;
	logic             pin_assert;
	logic             stop_prev_r;
	logic [SW-1:0]    st_cnt_r;
	logic             xtal_ready_r;
	logic [RW-1:0]    rcnt_r;
	logic             by_osc_r;
	logic             drive_r;
	logic             hold_src;
	logic             sw_rst;
	logic             kick;

	function automatic logic is_wr(input logic [REG_AW-1:0] a);
		is_wr = reg_wr && !sys_reset && (reg_addr == a);
	endfunction

	function automatic logic [CNT_W-1:0] int_last(input logic [1:0] s);
		logic [CNT_W-1:0] one;
		one = {{(CNT_W-1){1'b0}}, 1'b1};
		int_last = (one << (WD_BASE_LOG2 + SEL_SHIFT * int'(s))) - one;
	endfunction

	wdr_sync u_xtal_sync (
		.clock (clock),
		.rst_n (rst_n),
		.pin   (xtal_sense),
		.level (xtal_lvl)
	);

	wdr_sync u_pin_sync (
		.clock (clock),
		.rst_n (rst_n),
		.pin   (rst_pin_in),
		.level (pin_lvl)
	);

	assign sys_reset = (state_r != RS_RUN);

	// The clock input runs at four times the crystal, so every mode is a tick enable.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dcnt_r <= '0;
		end else begin
			dcnt_r <= dcnt_r + 1'b1;
		end
	end

	assign osc_en = &dcnt_r[OSC_LOG2-1:0];

	always_comb begin
		case (cd_r)
		CD_MULT: sys_en = ratio_r ? 1'b1 : dcnt_r[0];
		CD_SLOW: sys_en = &dcnt_r;
		default: sys_en = osc_en;
		endcase
	end

	assign sys_tick = sys_en;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sel_r <= '0;
		end else if (sys_reset) begin
			sel_r <= '0;
		end else if (is_wr(REG_CLOCK_CTRL)) begin
			sel_r <= reg_wdata[CK_SEL_HI:CK_SEL_LO];
		end
	end

	// A fast mode cannot be chosen before the multiplier has settled.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cd_r <= CD_DIV1;
			ctm_r <= 1'b0;
			ratio_r <= 1'b0;
		end else if (sys_reset) begin
			cd_r <= CD_DIV1;
			ctm_r <= 1'b0;
		end else if (is_wr(REG_POWER_MODE)) begin
			if (reg_wdata[PM_CD_HI:PM_CD_LO] != CD_MULT || mult_ready_r) begin
				cd_r <= reg_wdata[PM_CD_HI:PM_CD_LO];
			end
			if (cd_r == CD_DIV1 || cd_r == CD_RSV) begin
				ctm_r <= reg_wdata[PM_MULT_EN];
			end
			if (!ctm_r) begin
				ratio_r <= reg_wdata[PM_RATIO];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mult_ready_r <= 1'b0;
		end else if (!ctm_r) begin
			mult_ready_r <= 1'b0;
		end else if (sys_en && (&wd_cnt_r[WD_BASE_LOG2-1:0])) begin
			mult_ready_r <= 1'b1;
		end
	end

	assign mult_ready = mult_ready_r;

	// Any other write to the unlock register cancels a half-finished sequence.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ta_arm_r <= '0;
			ta_open_r <= '0;
		end else if (is_wr(REG_TIMED_ACCESS)) begin
			ta_arm_r <= (reg_wdata == TA_KEY1) ? TA_WINDOW : 2'h0;
			ta_open_r <= (reg_wdata == TA_KEY2 && ta_arm_r != 2'h0) ? TA_WINDOW : 2'h0;
		end else if (sys_en) begin
			if (ta_arm_r != 2'h0) begin
				ta_arm_r <= ta_arm_r - 1'b1;
			end
			if (ta_open_r != 2'h0) begin
				ta_open_r <= ta_open_r - 1'b1;
			end
		end
	end

	assign ta_open = (ta_open_r != 2'h0);
	assign restart_now = is_wr(REG_WD_CTRL) && reg_wdata[WDC_RESTART] && ta_open;
	assign int_hit = sys_en && (wd_cnt_r == int_last(sel_r));

	// The counter never stops outside reset, so idle periods keep timing.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wd_cnt_r <= '0;
		end else if (sys_reset || restart_now) begin
			wd_cnt_r <= '0;
		end else if (sys_en) begin
			wd_cnt_r <= int_hit ? '0 : wd_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 1'b0;
			pcnt_r <= '0;
		end else if (sys_reset || restart_now || wd_fire) begin
			pend_r <= 1'b0;
			pcnt_r <= '0;
		end else if (int_hit && ewt_r) begin
			pend_r <= 1'b1;
			pcnt_r <= '0;
		end else if (pend_r && sys_en) begin
			pcnt_r <= pcnt_r + 1'b1;
		end
	end

	assign wd_fire = pend_r && sys_en && (pcnt_r == WD_RST_LAST) && ewt_r && !restart_now;

	// Reset enable survives everything but power-on so a stuck program cannot drop it.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ewt_r <= 1'b0;
		end else if (is_wr(REG_WD_CTRL) && ta_open) begin
			ewt_r <= reg_wdata[WDC_RST_EN];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_irq_flag_r <= 1'b0;
		end else if (int_hit) begin
			watchdog_irq_flag_r <= 1'b1;
		end else if (is_wr(REG_WD_CTRL)) begin
			watchdog_irq_flag_r <= reg_wdata[WDC_IRQ_FLAG];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_reset_flag_r <= 1'b0;
		end else if (wd_fire) begin
			watchdog_reset_flag_r <= 1'b1;
		end else if (is_wr(REG_WD_CTRL)) begin
			watchdog_reset_flag_r <= reg_wdata[WDC_RST_FLAG];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_irq_enable_r <= 1'b0;
		end else if (sys_reset) begin
			watchdog_irq_enable_r <= 1'b0;
		end else if (is_wr(REG_EXT_IRQ_EN)) begin
			watchdog_irq_enable_r <= reg_wdata[EIE_WD_IRQ_EN];
		end
	end

	assign wd_irq_req = watchdog_irq_flag_r && watchdog_irq_enable_r;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			osc_fail_detect_enable_r <= 1'b0;
		end else if (pf_reset) begin
			osc_fail_detect_enable_r <= 1'b0;
		end else if (is_wr(REG_POWER_CTRL)) begin
			osc_fail_detect_enable_r <= reg_wdata[POWER_CONTROL_REG_OFD_EN];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			osc_fail_flag_r <= 1'b0;
		end else if (ofail) begin
			osc_fail_flag_r <= 1'b1;
		end else if (is_wr(REG_POWER_CTRL) && !reg_wdata[POWER_CONTROL_REG_OFD_FLAG]) begin
			osc_fail_flag_r <= 1'b0;
		end
	end

	// A crystal edge gap longer than one 20kHz period means the crystal has failed.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			xtal_prev_r <= 1'b0;
			gap_r <= '0;
		end else begin
			xtal_prev_r <= xtal_lvl;
			if (xtal_lvl != xtal_prev_r || stop_mode) begin
				gap_r <= '0;
			end else if (gap_r != GW'(OSC_FAIL_CYC)) begin
				gap_r <= gap_r + 1'b1;
			end
		end
	end

	assign ofail = osc_fail_detect_enable_r && !stop_mode && (gap_r == GW'(OSC_FAIL_CYC));

	// Our own drive is ignored, else the output pulse would re-trigger itself.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phc_r <= '0;
		end else if (!pin_lvl || drive_r) begin
			phc_r <= '0;
		end else if (osc_en && phc_r != PIN_HOLD_OSC) begin
			phc_r <= phc_r + 1'b1;
		end
	end

	assign pin_assert = (phc_r == PIN_HOLD_OSC);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stop_prev_r <= 1'b0;
			st_cnt_r <= '0;
			xtal_ready_r <= 1'b0;
		end else begin
			stop_prev_r <= stop_mode;
			if (stop_mode || stop_prev_r) begin
				st_cnt_r <= '0;
				xtal_ready_r <= 1'b0;
			end else if (!xtal_ready_r && osc_en) begin
				if (st_cnt_r == SW'(STARTUP_OSC - 1)) begin
					xtal_ready_r <= 1'b1;
				end else begin
					st_cnt_r <= st_cnt_r + 1'b1;
				end
			end
		end
	end

	assign xtal_ready = xtal_ready_r;
	assign hold_src = pin_assert || pf_reset || ofail;
	assign sw_rst = is_wr(REG_FLASH_CTRL) && (reg_wdata == FLASH_CMD_SYSRST);
	assign kick = wd_fire || sw_rst;

	// Power-on starts in the release count, so the crystal warmup gates the first run.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= RS_COUNT;
			rcnt_r <= '0;
			by_osc_r <= 1'b1;
		end else begin
			case (state_r)
			RS_RUN: begin
				if (hold_src) begin
					state_r <= RS_HOLD;
				end else if (kick) begin
					state_r <= RS_COUNT;
					rcnt_r <= RW'(RELEASE_OSC);
					by_osc_r <= 1'b1;
				end
			end
			RS_HOLD: begin
				if (!hold_src) begin
					state_r <= RS_COUNT;
					rcnt_r <= flash_busy ? RW'(FLASH_BUSY_CYC) : RW'(RELEASE_OSC);
					by_osc_r <= !flash_busy;
				end
			end
			RS_COUNT: begin
				if (hold_src) begin
					state_r <= RS_HOLD;
				end else if (rcnt_r == '0) begin
					if (xtal_ready_r) begin
						state_r <= RS_RUN;
					end
				end else if (!by_osc_r || osc_en) begin
					rcnt_r <= rcnt_r - 1'b1;
				end
			end
			default: state_r <= RS_COUNT;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			drive_r <= 1'b0;
		end else if ((kick && !sys_reset) || pf_reset || ofail) begin
			drive_r <= 1'b1;
		end else if (!sys_reset) begin
			drive_r <= 1'b0;
		end
	end

	assign rst_pin_oe = drive_r && sys_reset;
	assign rst_pin_out = rst_pin_oe;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
			REG_WD_CTRL:    reg_rdata <= {4'h0, watchdog_irq_flag_r, watchdog_reset_flag_r, ewt_r, 1'b0};
			REG_EXT_IRQ_EN: reg_rdata <= 8'(watchdog_irq_enable_r) << EIE_WD_IRQ_EN;
			REG_POWER_CTRL: reg_rdata <= {2'h0, osc_fail_flag_r, osc_fail_detect_enable_r, 4'h0};
			REG_CLOCK_CTRL: reg_rdata <= {sel_r, 6'h00};
			REG_POWER_MODE: reg_rdata <= {cd_r, 1'b0, ctm_r, ratio_r, 3'h0};
			default:        reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	logic [8:0] chk_cnt_r;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chk_cnt_r <= '0;
		end else if (int_hit) begin
			chk_cnt_r <= '0;
		end else if (sys_en && chk_cnt_r != 9'h1ff) begin
			chk_cnt_r <= chk_cnt_r + 1'b1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_timeout;
		int_hit && !sys_reset;
	endsequence

	sequence s_sw_cmd;
		sw_rst && !sys_reset;
	endsequence

	sequence s_stop_calm;
		stop_mode && !sys_reset && !pf_reset && !pin_assert && !kick;
	endsequence

	a_fire_delay: assert property (wd_fire |-> chk_cnt_r == 9'h1ff)
		else $error("watchdog reset not 512 ticks after timeout");
	a_sel_default: assert property (sys_reset |=> sel_r == 2'h0)
		else $error("interval select not defaulted in reset");
	a_fire_effect: assert property (wd_fire |=> sys_reset && watchdog_reset_flag_r && rst_pin_oe)
		else $error("watchdog reset did not take effect");
	a_restart_clear: assert property (restart_now |=> wd_cnt_r == '0 && !pend_r)
		else $error("restart did not clear the counter");
	a_irq_flag: assert property (s_timeout |=> watchdog_irq_flag_r)
		else $error("timeout did not set interrupt flag");
	a_sw_hold: assert property (s_sw_cmd |=> sys_reset[*8] ##1 rst_pin_oe)
		else $error("software reset too short");
	a_release_gate: assert property ($fell(sys_reset) |-> $past(rcnt_r) == '0 && xtal_ready_r)
		else $error("reset released early");
	a_pin_enter: assert property (pin_assert && !sys_reset |=> state_r == RS_HOLD)
		else $error("pin reset not entered");
	a_fail_flag: assert property (ofail |=> osc_fail_flag_r && sys_reset)
		else $error("oscillator failure not flagged");
	a_stop_quiet: assert property (s_stop_calm |=> !sys_reset)
		else $error("failure reset during stop mode");
	a_tick_rate: assert property (cd_r == CD_DIV1 && sys_en |-> osc_en)
		else $error("system tick off the oscillator rate");
endmodule
`default_nettype wire

// *** tb/wdr_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module wdr_far_end (
	input  wire logic clock,
	input  wire logic pin_oe,
	input  wire logic pin_out,
	input  wire logic ext_press,
	input  wire logic heavy_load,
	input  wire logic xtal_run,
	output logic      pin_level,
	output logic      xtal_sense
);
	// The pin has a pull-down; a large capacitor can keep the driven high from showing.
	assign pin_level = ext_press | (pin_oe & pin_out & ~heavy_load);
	logic half_r = 1'b0;
	initial xtal_sense = 1'b0;
	// A stopped crystal holds its level, so the detector sees no activity.
	// The crystal runs at a quarter of the clock, so it toggles every second edge.
	always @(posedge clock) begin
		if (xtal_run) begin
			half_r <= ~half_r;
			if (half_r) begin
				xtal_sense <= ~xtal_sense;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/wdr_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module wdr_top_tb_top;
	import wdr_pkg::*;
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       pf_reset = 1'b0;
	logic       flash_busy = 1'b0;
	logic       stop_mode = 1'b0;
	logic       press = 1'b0;
	logic       heavy = 1'b0;
	logic       run = 1'b1;
	logic       xtal_sense, pin_level, rst_pin_out, rst_pin_oe;
	logic       sys_reset, sys_tick, wd_irq_req, xtal_ready, mult_ready;
	logic       rd_d = 1'b0;
	logic [7:0] exp_q[$];
	string      nm_q[$];
	logic [7:0] e_v;
	string      n_v;
	int         fails = 0;
	int         checks = 0;
	int         cycles = 0;
	int         n, len, seed;

	always #5 clock = ~clock;

	wdr_top #(.WD_BASE_LOG2(4), .STARTUP_OSC(16), .FLASH_BUSY_CYC(50), .OSC_FAIL_CYC(40))
	u_wdr_top (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pf_reset(pf_reset),
		.flash_busy(flash_busy), .stop_mode(stop_mode), .xtal_sense(xtal_sense),
		.rst_pin_in(pin_level), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
		.sys_reset(sys_reset), .sys_tick(sys_tick), .wd_irq_req(wd_irq_req),
		.xtal_ready(xtal_ready), .mult_ready(mult_ready));

	wdr_far_end u_wdr_far_end (.clock(clock), .pin_oe(rst_pin_oe), .pin_out(rst_pin_out),
		.ext_press(press), .heavy_load(heavy), .xtal_run(run), .pin_level(pin_level),
		.xtal_sense(xtal_sense));

	task automatic end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Strobes are set on every call so no signal is assigned twice in one time step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		exp_q.push_back(e);
		nm_q.push_back(nm);
		@(posedge clock);
	endtask

	task automatic idle;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clock);
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: pick = sys_reset;
			1: pick = wd_irq_req;
			2: pick = xtal_ready;
			default: pick = mult_ready;
		endcase
	endfunction

	// Samples on the falling edge where outputs are settled, returns on a rising edge.
	task automatic wait_for(input int w, input logic lvl, input int lim, output int k);
		k = 0;
		@(negedge clock);
		while (pick(w) !== lvl && k < lim) begin
			@(negedge clock);
			k++;
		end
		@(posedge clock);
	endtask

	// Counts system ticks over forty clocks, then returns on a rising edge.
	task automatic count_ticks(output int k);
		k = 0;
		repeat (40) begin
			@(negedge clock);
			k += int'(sys_tick);
		end
		@(posedge clock);
	endtask

	always @(posedge clock) begin
		rd_d <= reg_rd;
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	// Read data stand only in the cycle after the strobe, so they are taken there.
	always @(negedge clock) begin
		if (rd_d) begin
			e_v = exp_q.pop_front();
			n_v = nm_q.pop_front();
			`CHK(n_v, e_v, reg_rdata)
		end
	end

	initial begin
		seed = 68;
		repeat (10) @(posedge clock);
		@(negedge clock);
		`CHK("oe in reset", 1'b0, rst_pin_oe)
		`CHK("reset in reset", 1'b1, sys_reset)
		@(posedge clock);
		rst_n <= 1'b1;
		wait_for(0, 1'b0, 500, n);
		`CHK("startup len", 1'b1, n >= 60 && n <= 90)
		rd(REG_WD_CTRL, 8'h00, "wd ctrl");
		rd(REG_CLOCK_CTRL, 8'h00, "interval");
		rd(8'h3c, 8'h00, "unmapped");
		wr(REG_EXT_IRQ_EN, 8'h10);
		idle();
		wait_for(1, 1'b1, 200, n);
		`CHK("first irq", 1'b1, n <= 70)
		rd(REG_WD_CTRL, 8'h08, "irq flag");
		wr(REG_WD_CTRL, 8'h00);
		idle();
		`CHK("irq cleared", 1'b0, wd_irq_req)
		wait_for(1, 1'b1, 100, n);
		`CHK("period", 1'b1, n >= 50 && n <= 70)
		wr(REG_WD_CTRL, 8'h00);
		wr(REG_CLOCK_CTRL, 8'h80);
		wr(REG_TIMED_ACCESS, TA_KEY1);
		wr(REG_TIMED_ACCESS, TA_KEY2);
		wr(REG_WD_CTRL, 8'h03);
		idle();
		wait_for(1, 1'b1, 4200, n);
		`CHK("x64 interval", 1'b1, n >= 4084 && n <= 4104)
		wait_for(0, 1'b1, 2200, n);
		`CHK("reset delay", 1'b1, n >= 2040 && n <= 2056)
		`CHK("wd pin", 1'b1, rst_pin_oe)
		wait_for(0, 1'b0, 600, n);
		`CHK("wd release", 1'b1, n >= 350 && n <= 380)
		rd(REG_WD_CTRL, 8'h0e, "cause");
		rd(REG_CLOCK_CTRL, 8'h00, "interval");
		rd(REG_EXT_IRQ_EN, 8'h00, "irq en");
		idle();
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		wait_for(0, 1'b0, 200, n);
		rd(REG_WD_CTRL, 8'h00, "por flags");
		idle();
		heavy <= 1'b1;
		wr(REG_FLASH_CTRL, FLASH_CMD_SYSRST);
		idle();
		`CHK("sw pin", 1'b1, rst_pin_oe & rst_pin_out & sys_reset)
		wait_for(0, 1'b0, 600, n);
		`CHK("sw len", 1'b1, n >= 350 && n <= 380)
		heavy <= 1'b0;
		press <= 1'b1;
		repeat (4) @(posedge clock);
		press <= 1'b0;
		repeat (30) @(posedge clock);
		`CHK("short press", 1'b0, sys_reset)
		len = 24 + ($random(seed) & 31);
		press <= 1'b1;
		repeat (len) @(posedge clock);
		`CHK("pin reset", 1'b1, sys_reset)
		press <= 1'b0;
		wait_for(0, 1'b0, 600, n);
		`CHK("pin release", 1'b1, n >= 355 && n <= 380)
		flash_busy <= 1'b1;
		press <= 1'b1;
		repeat (len) @(posedge clock);
		press <= 1'b0;
		wait_for(0, 1'b0, 200, n);
		`CHK("busy release", 1'b1, n >= 45 && n <= 65)
		flash_busy <= 1'b0;
		wr(REG_POWER_CTRL, 8'h10);
		stop_mode <= 1'b1;
		run <= 1'b0;
		repeat (100) @(posedge clock);
		`CHK("stop no reset", 1'b0, sys_reset)
		`CHK("stop xtal", 1'b0, xtal_ready)
		stop_mode <= 1'b0;
		run <= 1'b1;
		wait_for(2, 1'b1, 150, n);
		`CHK("stop restart", 1'b1, n >= 60 && n <= 75)
		run <= 1'b0;
		wait_for(0, 1'b1, 100, n);
		`CHK("osc fail", 1'b1, n >= 36 && n <= 50)
		rd(REG_POWER_CTRL, 8'h30, "fail flag");
		idle();
		`CHK("fail pin", 1'b1, rst_pin_oe)
		run <= 1'b1;
		wait_for(0, 1'b0, 600, n);
		pf_reset <= 1'b1;
		repeat (5) @(posedge clock);
		`CHK("pf pin", 1'b1, rst_pin_oe & sys_reset)
		pf_reset <= 1'b0;
		wait_for(0, 1'b0, 600, n);
		rd(REG_POWER_CTRL, 8'h20, "pf clears en");
		wr(REG_POWER_CTRL, 8'h00);
		rd(REG_POWER_CTRL, 8'h00, "flag cleared");
		wr(REG_POWER_MODE, 8'h90);
		idle();
		wait_for(3, 1'b1, 100, n);
		`CHK("mult ready", 1'b1, n <= 70)
		count_ticks(n);
		`CHK("tick div1", 10, n)
		wr(REG_POWER_MODE, 8'h10);
		rd(REG_POWER_MODE, 8'h10, "mode x2");
		idle();
		count_ticks(n);
		`CHK("tick x2", 20, n)
		repeat (4) @(posedge clock);
		end_of_test();
	end
endmodule
`default_nettype wire
